/* File: verilog/socket_pkg.sv */
// Purpose: Constants and types for the socket detect and power switch block
// Assumes: 50 MHz mclk, synchronous active-low reset
// Notes:   Register map is local to this block
// Operation
// (RQ1) Switch select 0: 1.8 V core CardBus card sets the low-voltage flag.
// (RQ2) Switch select 1: same card sets the X.X-volt flag instead; the code also keeps the low-voltage flag set via v33.
// (RQ3) Interrogate a card inserted into a cold socket before power; the switch word is not gated on the class, so power can come first.
// (RQ4) Classify 16-bit or CardBus and voltages from detect/sense terminals.
// (RQ5) CD1 tied to VS1 with VS2 grounded means low-voltage media adapter.
// (RQ6) Low level on SD socket detect means card inserted.
// (RQ7) Low level on second flash socket detect means card inserted.
// (RQ8) Debounce flash detect insertion over about 50 ms.
// (RQ9) Removal is seen immediately, no debounce.
// (RQ10) SD socket machine: empty off, inserted off, inserted on.
// (RQ11) Second flash socket has its own identical three-state machine.
// (RQ12) Drive the external switch over a three-wire serial link.
// (RQ13) Switch select is bit 10 of general control; resets to 1.8 V type.
// (RQ14) 1.8 V switch Vpp/Vcore codes per socket as D0,D1,D9 and D4,D5,D10.
// (RQ15) Vcc codes D3,D2 and D6,D7; low shutdown D8 makes outputs Hi-Z.
// (RQ16) 12 V switch Vpp codes: 00x 0V,010 3.3,011 5,10x 12,11x Hi-Z.
// (RQ17) Shift D0..D10 serially then latch; resend on any power change.
package socket_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] reg_gen_ctrl    = 8'h00;
   localparam logic [7:0] reg_present     = 8'h04;
   localparam logic [7:0] reg_pwr_req     = 8'h08;
   localparam logic [7:0] reg_irq_status  = 8'h0c;
   localparam logic [7:0] reg_irq_clear   = 8'h10;
   localparam logic [7:0] reg_irq_enable  = 8'h14;
   localparam logic [7:0] reg_media_state = 8'h18;
   // ==========================================================
   // Fields and reset values
   localparam int          sw_sel_bit      = 10;
   localparam logic [31:0] gen_ctrl_reset  = 32'h0000_0000;
   localparam logic [31:0] pwr_req_reset   = 32'h0000_0000;
   localparam logic [3:0]  irq_reset       = 4'h0;
   localparam int          irq_bits        = 4;
   // ==========================================================
   // Timing
   localparam int clk_hz          = 50_000_000;
   localparam int debounce_ms     = 50;
   localparam int debounce_cycles = (clk_hz / 1000) * debounce_ms;
   localparam int sclk_div_cycles = 25;
   localparam int word_bits       = 11;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      st_empty_off    = 2'b00,
      st_inserted_off = 2'b01,
      st_inserted_on  = 2'b10
   } media_state_e;
   typedef enum logic [1:0] {
      sh_idle  = 2'b00,
      sh_shift = 2'b01,
      sh_latch = 2'b10
   } shift_state_e;
   typedef struct packed {
      logic cd1;
      logic cd2;
      logic vs1;
      logic vs2;
      logic cd1_vs1;
      logic cd1_vs2;
      logic cd2_vs1;
      logic cd2_vs2;
   } sense_s;
   typedef struct packed {
      logic       cardbus;
      logic       card16;
      logic       v5;
      logic       v33;
      logic       vxx;
      logic       vyy;
      logic       adapter;
      logic       reserved;
      logic       core18;
   } card_class_s;
endpackage : socket_pkg

/* File: verilog/card_detect_power_switch_ctrl.sv */
// Purpose: Card classification, flash socket detect and switch control
// Assumes: Sense inputs are pin levels resolved by the pad into ground,
//          open and cross-connect indications
// Notes:   Power switch word shifts out MSB D10 first
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
module card_detect_power_switch_ctrl
   import socket_pkg::*;
#(
   parameter int debounce_count = debounce_cycles
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // PC Card sense terminals per socket
   input  wire sense_s      sense_a,
   input  wire sense_s      sense_b,
   // Flash media detect pins
   input  wire logic        sd_socket_detect_n,
   input  wire logic        flash2_socket_detect_n,
   // Power switch serial link
   output logic             sw_clock,
   output logic             sw_data,
   output logic             sw_latch,
   // Flash socket power enables
   output logic             sd_power_on,
   output logic             flash2_power_on,
   // Interrupt
   output logic             irq
);
   // ==========================================================
   // Synchronisers
   logic [1:0] sync_sd;
   logic [1:0] sync_f2;
   sense_s     sa_m, sa_s, sb_m, sb_s;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync_sd <= 2'h3;
         sync_f2 <= 2'h3;
         sa_m    <= '0;
         sa_s    <= '0;
         sb_m    <= '0;
         sb_s    <= '0;
      end else begin
         sync_sd <= {sync_sd[0], sd_socket_detect_n};
         sync_f2 <= {sync_f2[0], flash2_socket_detect_n};
         sa_m    <= sense_a;
         sa_s    <= sa_m;
         sb_m    <= sense_b;
         sb_s    <= sb_m;
      end
   end

   // ==========================================================
   // Classification
   // Encoding from the detect/voltage-sense table
   function automatic card_class_s classify(input sense_s s);
      card_class_s c;
      c = '0;
      if (s.cd1 && s.cd2) begin
         c.card16 = 1'b1;                                  // RQ4
         c.v33    = s.vs1;
         c.vxx    = s.vs2;
         c.v5     = s.vs1 | ~s.vs2;
      end else if (s.cd2 && s.cd1_vs1 && s.vs2) begin
         c.adapter = 1'b1;                                 // RQ5
      end else if (s.cd2 && s.cd1_vs1) begin
         c.cardbus = 1'b1;                                 // RQ4
         c.v33     = 1'b1;
      end else if (s.cd1 && s.cd2_vs2 && s.vs1) begin
         c.cardbus = 1'b1;
         c.v33     = 1'b1;
         c.vxx     = 1'b1;
      end else if (s.cd1 && s.cd2_vs2) begin
         c.cardbus = 1'b1;
         c.v33     = 1'b1;
         c.core18  = 1'b1;
      end else if (s.cd1 && s.cd2_vs1 && s.vs2) begin
         c.cardbus = 1'b1;
         c.v33     = 1'b1;
         c.vxx     = 1'b1;
         c.vyy     = 1'b1;
      end else if (s.cd1 && s.cd2_vs1) begin
         c.cardbus = 1'b1;
         c.vyy     = 1'b1;
      end else if (s.cd2 && s.cd1_vs2 && s.vs1) begin
         c.reserved = 1'b1;
      end else if (s.cd2 && s.cd1_vs2) begin
         c.cardbus = 1'b1;
         c.vxx     = 1'b1;
         c.vyy     = 1'b1;
      end
      return c;
   endfunction : classify

   function automatic logic present(input sense_s s);
      return s.cd1 | s.cd2 | s.cd1_vs1 | s.cd1_vs2 | s.cd2_vs1 | s.cd2_vs2;
   endfunction : present

   // ==========================================================
   // Registers
   logic [31:0]    gen_ctrl;
   logic [31:0]    pwr_req;
   logic [irq_bits-1:0] irq_status;
   logic [irq_bits-1:0] irq_enable;
   logic [1:0]     cold;
   card_class_s    cls_a, cls_b;
   logic           sw_sel;
   assign sw_sel = gen_ctrl[sw_sel_bit];

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gen_ctrl <= gen_ctrl_reset;                       // RQ13
         pwr_req  <= pwr_req_reset;
      end else if (reg_wr) begin
         if (reg_addr == reg_gen_ctrl) gen_ctrl <= reg_wdata;
         if (reg_addr == reg_pwr_req)  pwr_req  <= reg_wdata;
      end
   end

   // Latch class only while socket is cold; the switch word is not gated on it, so power can precede it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cls_a <= '0;
         cls_b <= '0;
         cold  <= 2'h3;
      end else begin
         if (!present(sa_s)) begin
            cold[0] <= 1'b1;
            cls_a   <= '0;
         end else if (cold[0]) begin
            cls_a   <= classify(sa_s);                     // RQ3
            cold[0] <= 1'b0;
         end
         if (!present(sb_s)) begin
            cold[1] <= 1'b1;
            cls_b   <= '0;
         end else if (cold[1]) begin
            cls_b   <= classify(sb_s);                     // RQ3
            cold[1] <= 1'b0;
         end
      end
   end

   function automatic logic [15:0] present_word(input card_class_s c,
                                                input logic sel);
      logic [15:0] w;
      w = '0;
      w[0] = c.card16;
      w[1] = c.cardbus;
      w[2] = c.v5;
      w[3] = c.v33 | (c.core18 & ~sel);                    // RQ1
      w[4] = c.vxx | (c.core18 & sel);                     // RQ2
      w[5] = c.vyy;
      w[6] = c.adapter;
      w[7] = c.reserved;
      return w;
   endfunction : present_word

   // ==========================================================
   // Flash socket debounce and state machines
   logic [1:0]     inserted;
   logic [1:0]     raw_in;
   logic [31:0]    db_cnt [2];
   media_state_e   mstate [2];
   assign raw_in = {~sync_f2[1], ~sync_sd[1]};              // RQ6 RQ7

   generate
      for (genvar i = 0; i < 2; i++) begin : g_media
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               db_cnt[i]   <= '0;
               inserted[i] <= 1'b0;
            end else if (!raw_in[i]) begin
               db_cnt[i]   <= '0;
               inserted[i] <= 1'b0;                        // RQ9
            end else if (!inserted[i]) begin
               if (db_cnt[i] >= 32'(debounce_count - 1)) begin
                  inserted[i] <= 1'b1;                     // RQ8
               end else begin
                  db_cnt[i] <= db_cnt[i] + 32'h1;
               end
            end
         end
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               mstate[i] <= st_empty_off;
            end else begin
               case (mstate[i])                            // RQ10 RQ11
                  st_empty_off:
                     if (inserted[i]) mstate[i] <= st_inserted_off;
                  st_inserted_off:
                     if (!inserted[i]) mstate[i] <= st_empty_off;
                     else if (pwr_req[16+i]) mstate[i] <= st_inserted_on;
                  st_inserted_on:
                     if (!inserted[i]) mstate[i] <= st_empty_off;
                     else if (!pwr_req[16+i]) mstate[i] <= st_inserted_off;
                  default: mstate[i] <= st_empty_off;
               endcase
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sd_power_on     <= 1'b0;
         flash2_power_on <= 1'b0;
      end else begin
         sd_power_on     <= (mstate[0] == st_inserted_on);
         flash2_power_on <= (mstate[1] == st_inserted_on);
      end
   end

   // ==========================================================
   // Switch word
   // Request: [2:0] socket A vpp code, [4:3] A vcc, [7:5] B vpp,
   // [9:8] B vcc, [10] switch_shutdown_n
   logic [10:0] next_word;
   logic [10:0] sent_word;
   logic        switch_shutdown_n;
   assign switch_shutdown_n = pwr_req[10];
   always_comb begin
      next_word     = '0;
      // Same bit placement serves both switch types; only meaning differs
      next_word[0]  = pwr_req[2];                          // RQ14 RQ16
      next_word[1]  = pwr_req[1];
      next_word[9]  = pwr_req[0];
      next_word[3]  = pwr_req[4];                          // RQ15
      next_word[2]  = pwr_req[3];
      next_word[4]  = pwr_req[7];
      next_word[5]  = pwr_req[6];
      next_word[10] = pwr_req[5];
      next_word[6]  = pwr_req[9];
      next_word[7]  = pwr_req[8];
      next_word[8]  = switch_shutdown_n;                   // RQ15 RQ16
   end

   // ==========================================================
   // Serial shifter
   shift_state_e sh_state;
   logic [10:0]  shreg;
   logic [3:0]   bit_cnt;
   logic [7:0]   div_cnt;
   logic         tick;
   logic         pend;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_cnt <= '0;
         tick    <= 1'b0;
      end else if (div_cnt == 8'(sclk_div_cycles - 1)) begin
         div_cnt <= '0;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 8'h1;
         tick    <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sh_state  <= sh_idle;
         shreg     <= '0;
         bit_cnt   <= '0;
         sent_word <= '0;
         pend      <= 1'b1;
         sw_clock  <= 1'b0;
         sw_data   <= 1'b0;
         sw_latch  <= 1'b0;
      end else begin
         if (next_word != sent_word) pend <= 1'b1;         // RQ17
         if (tick) begin
            case (sh_state)                                // RQ12
               sh_idle: begin
                  sw_latch <= 1'b0;
                  if (pend) begin
                     shreg     <= next_word;
                     sent_word <= next_word;
                     pend      <= 1'b0;
                     bit_cnt   <= '0;
                     sh_state  <= sh_shift;
                  end
               end
               sh_shift: begin
                  if (!sw_clock) begin
                     sw_data  <= shreg[10];
                     sw_clock <= 1'b1;
                  end else begin
                     sw_clock <= 1'b0;
                     shreg    <= {shreg[9:0], 1'b0};
                     if (bit_cnt == 4'(word_bits - 1)) begin
                        sh_state <= sh_latch;
                     end else begin
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               sh_latch: begin
                  sw_latch <= 1'b1;                        // RQ17
                  sh_state <= sh_idle;
               end
               default: sh_state <= sh_idle;
            endcase
         end
      end
   end

   // ==========================================================
   // Interrupts: SD insert change, flash2 change, socket A/B change
   logic [irq_bits-1:0] ev;
   logic [1:0]          ins_d;
   logic [1:0]          cold_d;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ins_d  <= '0;
         cold_d <= 2'h3;
      end else begin
         ins_d  <= inserted;
         cold_d <= cold;
      end
   end
   assign ev = {cold ^ cold_d, inserted ^ ins_d};

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_status <= irq_reset;
         irq_enable <= irq_reset;
      end else begin
         // Set wins over a same-cycle clear
         if (reg_wr && reg_addr == reg_irq_clear) begin
            irq_status <= (irq_status & ~reg_wdata[irq_bits-1:0]) | ev;
         end else begin
            irq_status <= irq_status | ev;
         end
         if (reg_wr && reg_addr == reg_irq_enable) begin
            irq_enable <= reg_wdata[irq_bits-1:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) irq <= 1'b0;
      else        irq <= |(irq_status & irq_enable);
   end

   // ==========================================================
   // Read port
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            reg_gen_ctrl: reg_rdata <= gen_ctrl;
            reg_present:  reg_rdata <= {present_word(cls_b, sw_sel),
                                        present_word(cls_a, sw_sel)};
            reg_pwr_req:  reg_rdata <= pwr_req;
            reg_irq_status: reg_rdata <= {28'h0, irq_status};
            reg_irq_enable: reg_rdata <= {28'h0, irq_enable};
            reg_media_state: reg_rdata <= {28'h0, mstate[1], mstate[0]};
            default:      reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end
endmodule : card_detect_power_switch_ctrl

/* File: bench/socket_properties.sv */
// Purpose: Port assertions for the socket detect and switch block
// Assumes: One mclk domain, synchronous active-low reset
// Notes:   Bound to the top module by the statement at the foot
`timescale 1ns/1ps
module socket_properties
   import socket_pkg::*;
#(
   parameter int debounce_count = 20
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Detect pins and power enables
   input wire logic sd_socket_detect_n,
   input wire logic flash2_socket_detect_n,
   input wire logic sd_power_on,
   input wire logic flash2_power_on,
   // Switch link
   input wire logic sw_clock,
   input wire logic sw_data,
   input wire logic sw_latch
);
   // ==========================================================
   // Helper counters
   int   sd_low;
   int   f2_low;
   int   n_clk;
   logic clk_d;
   logic lat_d;
   // Saturate so a long insertion never wraps
   always_ff @(posedge mclk) begin
      sd_low <= sd_socket_detect_n ? 0
                : sd_low + int'(sd_low < debounce_count);
      f2_low <= flash2_socket_detect_n ? 0
                : f2_low + int'(f2_low < debounce_count);
   end
   always_ff @(posedge mclk) begin
      clk_d <= sw_clock;
      lat_d <= sw_latch;
      if (!rst_n || (sw_latch && !lat_d)) n_clk <= 0;
      else if (sw_clock && !clk_d) n_clk <= n_clk + 1;
   end
   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_SD_DEBOUNCE: assert property (
      $rose(sd_power_on) |-> sd_low >= debounce_count)
      else $error("sd power before debounce");
   AST_F2_DEBOUNCE: assert property (
      $rose(flash2_power_on) |-> f2_low >= debounce_count)
      else $error("flash2 power before debounce");
   AST_SD_REMOVE: assert property (
      sd_socket_detect_n [*8] |-> !sd_power_on)
      else $error("sd power kept after removal");
   AST_F2_REMOVE: assert property (
      flash2_socket_detect_n [*8] |-> !flash2_power_on)
      else $error("flash2 power kept after removal");
   AST_LATCH_LEN: assert property (
      $rose(sw_latch) |-> sw_latch [*8] ##17 sw_latch ##1 !sw_latch)
      else $error("latch pulse length wrong");
   AST_CLK_HIGH: assert property (
      $rose(sw_clock) |-> ##24 sw_clock ##1 !sw_clock)
      else $error("switch clock high time wrong");
   AST_DATA_HOLD: assert property (
      sw_clock && $past(sw_clock) |-> $stable(sw_data))
      else $error("switch data moved while clock high");
   AST_LATCH_IDLE: assert property (
      sw_latch |-> !sw_clock)
      else $error("switch clock during latch");
   AST_BIT_COUNT: assert property (
      $rose(sw_latch) |-> n_clk == word_bits)
      else $error("wrong bit count before latch");
endmodule : socket_properties

bind card_detect_power_switch_ctrl socket_properties #(
   .debounce_count(debounce_count)
) u_props (
   .mclk(mclk),
   .rst_n(rst_n),
   .sd_socket_detect_n(sd_socket_detect_n),
   .flash2_socket_detect_n(flash2_socket_detect_n),
   .sd_power_on(sd_power_on),
   .flash2_power_on(flash2_power_on),
   .sw_clock(sw_clock),
   .sw_data(sw_data),
   .sw_latch(sw_latch)
);

/* File: bench/switch_model.sv */
// Purpose: External socket power switch seen over the serial link
// Assumes: Link signals change only at mclk edges
// Notes:   Supplies in mV, -1 for high impedance; socket A only
`timescale 1ns/1ps
module switch_model
   import socket_pkg::*;
#(
   parameter bit twelve_volt = 1'b0
) (
   // Link from the block
   input  wire logic        mclk,
   input  wire logic        sw_clock,
   input  wire logic        sw_data,
   input  wire logic        sw_latch,
   // Latched word and decoded supplies
   output logic      [10:0] word,
   output int               vcc_a,
   output int               vpp_a
);
   logic [10:0] shift;
   logic        clk_d;
   logic        lat_d;
   // ==========================================================
   // Shift and latch
   always @(posedge mclk) begin
      clk_d <= sw_clock;
      lat_d <= sw_latch;
      if (sw_clock && !clk_d) shift <= {shift[9:0], sw_data};
      if (sw_latch && !lat_d) word <= shift;
   end
   // ==========================================================
   // Output decode
   always_comb begin
      case ({word[3], word[2]})
         2'b01:   vcc_a = 3300;
         2'b10:   vcc_a = 5000;
         default: vcc_a = 0;
      endcase
      case ({word[0], word[1], word[9]})
         3'b010:         vpp_a = 3300;
         3'b011:         vpp_a = 5000;
         3'b100, 3'b101: vpp_a = twelve_volt ? 12000 : -1;
         3'b110:         vpp_a = -1;
         3'b111:         vpp_a = twelve_volt ? -1 : 1800;
         default:        vpp_a = 0;
      endcase
      if (!word[8]) begin
         vcc_a = -1;
         vpp_a = -1;
      end
   end
endmodule : switch_model

/* File: bench/card_detect_power_switch_ctrl_tb.sv */
// Purpose: Self-checking bench for the socket detect and switch block
// Assumes: Short debounce count so insertions settle quickly
// Notes:   Random stimulus from a bench LFSR seeded with 12
`timescale 1ns/1ps
module card_detect_power_switch_ctrl_tb import socket_pkg::*;;
   localparam int deb = 20;
   logic        mclk, rst_n, reg_wr, reg_rd, sd_det_n, f2_det_n;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   sense_s      sense_a, sense_b;
   logic        sw_clock, sw_data, sw_latch, sd_pwr, f2_pwr, irq;
   logic [10:0] word, v;
   logic [15:0] lfsr;
   int          vcc_a, vpp_a, n_fail, n_tests;
   logic [7:0]  cls [4] = '{8'hc0, 8'h48, 8'h58, 8'h64};
   logic [7:0]  msk [4] = '{8'h05, 8'h0a, 8'h40, 8'h80};

   card_detect_power_switch_ctrl #(.debounce_count(deb))
      i_card_detect_power_switch_ctrl (
      .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sense_a(sense_a), .sense_b(sense_b),
      .sd_socket_detect_n(sd_det_n), .flash2_socket_detect_n(f2_det_n),
      .sw_clock(sw_clock), .sw_data(sw_data), .sw_latch(sw_latch),
      .sd_power_on(sd_pwr), .flash2_power_on(f2_pwr), .irq(irq));
   switch_model i_switch_model (
      .mclk(mclk), .sw_clock(sw_clock), .sw_data(sw_data),
      .sw_latch(sw_latch), .word(word), .vcc_a(vcc_a), .vpp_a(vpp_a));

   // ==========================================================
   // Helpers
   function automatic logic [15:0] next_rand(logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : next_rand
   // Request bits to D10..D0 placement
   function automatic logic [10:0] exp_word(logic [10:0] r);
      return {r[5], r[0], r[10], r[8], r[9], r[6], r[7], r[4], r[3],
              r[1], r[2]};
   endfunction : exp_word
   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
   endtask : cyc
   task automatic check(string what, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : check
   // Gap cycle after each strobe keeps one assignment per time step
   task automatic wr(logic [7:0] a, logic [31:0] x);
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      cyc(1);
      reg_wr <= 1'b0;
      cyc(1);
   endtask : wr
   task automatic rd_chk(logic [7:0] a, logic [31:0] m, logic [31:0] e,
                         string what);
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc(1);
      reg_rd <= 1'b0;
      cyc(1);
      check(what, e, reg_rdata & m);
   endtask : rd_chk
   task automatic set_det(int s, logic x);
      if (s == 1) f2_det_n <= x;
      else sd_det_n <= x;
   endtask : set_det
   task automatic wait_word(logic [10:0] e);
      int k;
      k = 0;
      while (word !== e && k < 3000) begin
         cyc(1);
         k++;
      end
      check("switch word", {21'h0, e}, {21'h0, word});
   endtask : wait_word
   task automatic final_report;
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   // ==========================================================
   // Clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      cyc(50000);
      n_fail++;
      final_report();
   end

   // ==========================================================
   // Main sequence
   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {sense_a, sense_b, n_fail, n_tests} = '0;
      {sd_det_n, f2_det_n} = 2'b11;
      lfsr = 16'h000c;
      cyc(5);
      rst_n <= 1'b1;
      cyc(2);
      rd_chk(reg_gen_ctrl, 32'h400, 32'h0, "switch select");
      rd_chk(8'hfc, 32'hffff_ffff, 32'h0, "unmapped read");
      for (int i = 0; i < 4; i++) begin
         sense_b <= sense_s'(cls[i]);
         cyc(6);
         rd_chk(reg_present, {8'h0, msk[i], 16'h0}, {8'h0, msk[i], 16'h0},
                "class");
         sense_b <= sense_s'(8'hc0);
         cyc(6);
         rd_chk(reg_present, {8'h0, msk[i], 16'h0}, {8'h0, msk[i], 16'h0},
                "class held");
         sense_b <= '0;
         cyc(6);
      end
      for (int s = 0; s < 2; s++) begin
         wr(reg_gen_ctrl, 32'(s) << sw_sel_bit);
         sense_a <= sense_s'(8'h81);
         cyc(6);
         rd_chk(reg_present, s ? 32'h10 : 32'h18, s ? 32'h10 : 32'h08,
                "core card flag");
         sense_a <= '0;
         cyc(6);
      end
      wr(reg_irq_clear, 32'hf);
      wr(reg_irq_enable, 32'hf);
      for (int s = 0; s < 2; s++) begin
         lfsr = next_rand(lfsr);
         set_det(s, 1'b0);
         cyc(deb - 4 + int'(lfsr[1:0]));
         set_det(s, 1'b1);
         cyc(6);
         rd_chk(reg_media_state, 32'h3 << 2 * s, 0, "glitch");
         rd_chk(reg_irq_status, 32'h1 << s, 0, "glitch event");
         set_det(s, 1'b0);
         cyc(deb + 8);
         rd_chk(reg_media_state, 32'h3 << 2 * s, 32'h1 << 2 * s,
                "inserted");
         rd_chk(reg_irq_status, 32'h1 << s, 32'h1 << s, "status");
         check("irq raised", 1, irq);
         wr(reg_irq_enable, 32'h0);
         cyc(2);
         check("irq masked", 0, irq);
         wr(reg_pwr_req, 32'h1 << (16 + s));
         cyc(4);
         rd_chk(reg_media_state, 32'h3 << 2 * s, 32'h2 << 2 * s,
                "powered");
         check("power on", 1, s ? f2_pwr : sd_pwr);
         set_det(s, 1'b1);
         cyc(5);
         rd_chk(reg_media_state, 32'h3 << 2 * s, 0, "removed");
         check("power off", 0, s ? f2_pwr : sd_pwr);
         wr(reg_irq_clear, 32'hf);
         wr(reg_irq_enable, 32'hf);
         cyc(2);
         check("irq cleared", 0, irq);
      end
      for (int i = 0; i < 6; i++) begin
         lfsr = next_rand(lfsr);
         v = (i == 0) ? 11'h7ff : (i == 1) ? 11'h40a : lfsr[10:0];
         if (i == 4) wr(reg_pwr_req, {21'h0, ~v});
         wr(reg_pwr_req, {21'h0, v});
         wait_word(exp_word(v));
         if (i == 0) check("vpp core", 1800, vpp_a);
         if (i == 1) begin
            check("vcc a", 3300, vcc_a);
            check("vpp a", 3300, vpp_a);
         end
      end
      final_report();
   end
endmodule : card_detect_power_switch_ctrl_tb
